// ===== mbae_pkg.sv
// Constants, types and decode helpers for the bit and arithmetic instruction executor
package mbae_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // Bus and register map
  localparam int unsigned ADDR_W = 12;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [ADDR_W-1:0] OFS_INSTR = 12'h000;
  localparam logic [ADDR_W-1:0] OFS_ACC = 12'h004;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 12'h008;
  localparam logic [ADDR_W-1:0] OFS_WDT = 12'h00C;
  localparam logic [ADDR_W-1:0] OFS_CYCLES = 12'h010;
  // File registers sit at FILE_BASE + 4 * file address
  localparam logic [2:0] FILE_SEL = 3'h1;
  localparam int unsigned FILE_SEL_LSB = 9;
  localparam int unsigned FILE_AW = 7;

  ////////////////////////////////////////////////////////////////////////////////
  // Status layout and reset values
  localparam int unsigned ST_SKIP = 5;
  localparam logic [13:0] INSTR_RST = 14'h0000;
  localparam logic [7:0] ACC_RST = 8'h00;
  localparam logic [4:0] FLAGS_RST = 5'h18;
  localparam logic [1:0] CYC_ONE = 2'h1;
  localparam logic [1:0] CYC_TWO = 2'h2;

  ////////////////////////////////////////////////////////////////////////////////
  // Opcode fields
  localparam logic [3:0] OPC_BCLR = 4'h4;
  localparam logic [3:0] OPC_BSET = 4'h5;
  localparam logic [3:0] OPC_BTSC = 4'h6;
  localparam logic [5:0] OPC_COMPLEMENT_FILE = 6'h09;
  localparam logic [5:0] OPC_DECREMENT_FILE = 6'h03;
  localparam logic [5:0] OPC_DECSZ = 6'h0B;
  localparam logic [5:0] OPC_SUBF = 6'h02;
  localparam logic [4:0] OPC_SUBL = 5'h1E;
  localparam logic [13:0] OPC_WDTCLR = 14'h0064;

  typedef enum {OP_NOP, OP_BCLR, OP_BSET, OP_BTSC, OP_WDTCLR, OP_COMPLEMENT_FILE, OP_DECREMENT_FILE,
                OP_DECSZ, OP_SUBL, OP_SUBF} mbae_op_t;
  typedef enum {B_IDLE, B_SERVE, B_RDATA} mbae_bus_st_t;
  typedef enum {E_IDLE, E_READ, E_EXEC, E_NOP} mbae_ex_st_t;

  typedef struct packed {
    logic watchdog_expired_flag;
    logic sleep_entered_flag;
    logic null_result_flag;
    logic digit_borrow_not_flag;
    logic borrow_not_flag;
  } mbae_flags_t;

  typedef struct packed {
    mbae_op_t op;
    logic dest;
    logic [2:0] bidx;
    logic [FILE_AW-1:0] faddr;
    logic [7:0] lit;
  } mbae_dec_t;

  function automatic mbae_dec_t mbae_decode(input logic [13:0] iw);
    mbae_dec_t d;
    d.op = OP_NOP;
    d.dest = iw[7];
    d.bidx = iw[9:7];
    d.faddr = iw[6:0];
    d.lit = iw[7:0];
    if (iw == OPC_WDTCLR) d.op = OP_WDTCLR;
    else if (iw[13:10] == OPC_BCLR) d.op = OP_BCLR;
    else if (iw[13:10] == OPC_BSET) d.op = OP_BSET;
    else if (iw[13:10] == OPC_BTSC) d.op = OP_BTSC;
    else if (iw[13:9] == OPC_SUBL) d.op = OP_SUBL;
    else if (iw[13:8] == OPC_COMPLEMENT_FILE) d.op = OP_COMPLEMENT_FILE;
    else if (iw[13:8] == OPC_DECREMENT_FILE) d.op = OP_DECREMENT_FILE;
    else if (iw[13:8] == OPC_DECSZ) d.op = OP_DECSZ;
    else if (iw[13:8] == OPC_SUBF) d.op = OP_SUBF;
    return d;
  endfunction : mbae_decode

  // Ops whose result goes to accumulator or file register by the destination bit
  function automatic logic mbae_has_dest(input mbae_op_t op);
    return op inside {OP_COMPLEMENT_FILE, OP_DECREMENT_FILE, OP_DECSZ, OP_SUBF};
  endfunction : mbae_has_dest

endpackage : mbae_pkg

// ===== mbae_file_ram.sv
// File register memory with registered read data
`timescale 1ns/1ps
module mbae_file_ram #(
  parameter int unsigned AW = 7,
  parameter int unsigned DW = 8
) (
  input wire logic clk_i,
  input wire logic ce_i,
  input wire logic we_i,
  input wire logic [AW-1:0] waddr_i,
  input wire logic [DW-1:0] wdata_i,
  input wire logic [AW-1:0] raddr_i,
  output logic [DW-1:0] rdata_o
);

  logic [DW-1:0] mem [0:(1<<AW)-1];

  always_ff @(posedge clk_i) begin
    if (ce_i) begin
      if (we_i) begin
        mem[waddr_i] <= wdata_i;
      end
      rdata_o <= mem[raddr_i];
    end
  end

endmodule : mbae_file_ram

// ===== mbae_core.sv
// Instruction executor for bit, decrement, complement and subtract ops with AHB-Lite access
//
// Notes on behaviour
// - bit_set_op forces chosen file bit to one, flags untouched, one cycle.
// - bit_clear_op forces chosen file bit to zero, flags untouched, one cycle.
// - bit_test_skip_if_clear on clear bit discards next, runs no-op, two cycles.
// - watchdog_clear_op zeroes counter and prescaler, sets expired and sleep flags.
// - complement_file inverts register into chosen destination, updates zero flag.
// - decrement_file subtracts one into destination, zero flag set on zero result.
// - decrement_skip_if_zero decrements, flags untouched, skips on zero result.
// - subtract_acc_from_literal puts literal minus accumulator in accumulator, updates flags.
// - subtract_acc_from_file puts register minus accumulator in destination, updates flags.
// - Borrow flag one when difference non-negative, zero when negative, wraps 256.
//
// Register access over AHB-Lite and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
module mbae_core
  import mbae_pkg::*;
#(
  parameter int unsigned WDT_PRE_W = 8,
  parameter int unsigned WDT_CNT_W = 8
) (
  input wire logic MCLK_I,
  input wire logic RESET_I,
  input wire logic CE_I,
  input wire logic HSEL_I,
  input wire logic [ADDR_W-1:0] HADDR_I,
  input wire logic [1:0] HTRANS_I,
  input wire logic HWRITE_I,
  input wire logic [2:0] HSIZE_I,
  input wire logic [31:0] HWDATA_I,
  input wire logic HREADY_I,
  output logic [31:0] HRDATA_O,
  output logic HREADYOUT_O,
  output logic HRESP_O
);

  ////////////////////////////////////////////////////////////////////////////////
  // State
  mbae_bus_st_t bst;
  logic [ADDR_W-1:0] baddr;
  logic bwr;
  mbae_ex_st_t est;
  logic [13:0] instr;
  logic [7:0] acc;
  mbae_flags_t flags;
  mbae_flags_t next_flags;
  logic skip;
  logic [1:0] last_cycles;
  logic [WDT_PRE_W-1:0] wdt_pre;
  logic [WDT_CNT_W-1:0] wdt_cnt;
  logic mem_we;
  logic [FILE_AW-1:0] mem_waddr;
  logic [FILE_AW-1:0] mem_raddr;
  logic [7:0] mem_wdata;
  logic [7:0] mem_rdata;
  logic [7:0] alu;

  ////////////////////////////////////////////////////////////////////////////////
  // Bus decode
  wire take = HSEL_I && (HTRANS_I == HTRANS_NONSEQ) && HREADY_I && (bst == B_IDLE);
  wire serve = (bst == B_SERVE) && (est == E_IDLE);
  wire hit_file = (baddr[ADDR_W-1:FILE_SEL_LSB] == FILE_SEL);
  wire [FILE_AW-1:0] bus_fidx = baddr[FILE_AW+1:2];
  wire bus_wr = serve && bwr;
  wire bus_wr_instr = bus_wr && (baddr == OFS_INSTR);
  wire bus_wr_acc = bus_wr && (baddr == OFS_ACC);
  wire bus_wr_status = bus_wr && (baddr == OFS_STATUS);
  wire bus_wr_file = bus_wr && hit_file;

  // Word width of a transfer is fixed; HSIZE_I carries no meaning here
  wire size_unused = ^HSIZE_I;

  ////////////////////////////////////////////////////////////////////////////////
  // Instruction decode and datapath
  mbae_dec_t dec;
  assign dec = mbae_decode(instr);

  wire exec = (est == E_EXEC);
  wire exec_ce = exec && CE_I;
  wire [7:0] bmask = 8'h01 << dec.bidx;
  wire bit_is_clear = ((mem_rdata & bmask) == 8'h00);
  wire [7:0] sub_a = (dec.op == OP_SUBL) ? dec.lit : mem_rdata;
  wire [8:0] sub_diff = {1'b0, sub_a} - {1'b0, acc};
  wire [4:0] nib_diff = {1'b0, sub_a[3:0]} - {1'b0, acc[3:0]};
  wire is_sub = (dec.op == OP_SUBL) || (dec.op == OP_SUBF);
  wire upd_zero = (dec.op == OP_COMPLEMENT_FILE) || (dec.op == OP_DECREMENT_FILE) || is_sub;
  wire res_zero = (alu == 8'h00);
  wire wdt_clr = exec && (dec.op == OP_WDTCLR);
  wire wdt_wrap = (&wdt_pre) && (&wdt_cnt);

  // Destination bit picks the target of the result
  wire to_file = (dec.op == OP_BCLR) || (dec.op == OP_BSET) ||
                 (mbae_has_dest(dec.op) && dec.dest);
  wire to_acc = (dec.op == OP_SUBL) || (mbae_has_dest(dec.op) && !dec.dest);

  wire take_skip = ((dec.op == OP_BTSC) && bit_is_clear) ||
                   ((dec.op == OP_DECSZ) && res_zero);

  always_comb begin
    unique case (dec.op)
      OP_BCLR: alu = mem_rdata & ~bmask;
      OP_BSET: alu = mem_rdata | bmask;
      OP_COMPLEMENT_FILE: alu = ~mem_rdata;
      OP_DECREMENT_FILE, OP_DECSZ: alu = mem_rdata - 8'h01;
      OP_SUBL, OP_SUBF: alu = sub_diff[7:0];
      OP_NOP, OP_BTSC, OP_WDTCLR: alu = mem_rdata;
    endcase
  end

  always_comb begin
    next_flags = flags;
    if (bus_wr_status) begin
      next_flags = mbae_flags_t'(HWDATA_I[4:0]);
    end
    if (exec) begin
      if (upd_zero) begin
        next_flags.null_result_flag = res_zero;
      end
      if (is_sub) begin
        next_flags.borrow_not_flag = ~sub_diff[8];
        next_flags.digit_borrow_not_flag = ~nib_diff[4];
      end
      if (wdt_clr) begin
        next_flags.watchdog_expired_flag = 1'b1;
        next_flags.sleep_entered_flag = 1'b1;
      end
    end
    // A timeout is never lost to a software write in the same cycle
    if (wdt_wrap && !wdt_clr) begin
      next_flags.watchdog_expired_flag = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // File register memory, shared by execution and bus
  assign mem_we = (exec && to_file) || bus_wr_file;
  assign mem_waddr = exec ? dec.faddr : bus_fidx;
  assign mem_wdata = exec ? alu : HWDATA_I[7:0];
  assign mem_raddr = (est == E_READ) ? dec.faddr : bus_fidx;

  mbae_file_ram #(
    .AW(FILE_AW),
    .DW(8)
  ) u_ram (
    .clk_i(MCLK_I),
    .ce_i(CE_I),
    .we_i(mem_we),
    .waddr_i(mem_waddr),
    .wdata_i(mem_wdata),
    .raddr_i(mem_raddr),
    .rdata_o(mem_rdata)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Read data selection
  wire [31:0] rd_status = {26'h0, skip, flags};
  wire [31:0] rd_wdt = 32'({wdt_pre, wdt_cnt});
  wire [31:0] rd_mux = hit_file ? {24'h0, mem_rdata} :
                       (baddr == OFS_INSTR) ? {18'h0, instr} :
                       (baddr == OFS_ACC) ? {24'h0, acc} :
                       (baddr == OFS_STATUS) ? rd_status :
                       (baddr == OFS_WDT) ? rd_wdt :
                       (baddr == OFS_CYCLES) ? {30'h0, last_cycles} : 32'h0000_0000;

  ////////////////////////////////////////////////////////////////////////////////
  // AHB-Lite slave
  always_ff @(posedge MCLK_I) begin
    if (RESET_I) begin
      bst <= B_IDLE;
      baddr <= '0;
      bwr <= 1'b0;
      HREADYOUT_O <= 1'b1;
      HRDATA_O <= 32'h0000_0000;
      HRESP_O <= 1'b0;
    end else if (CE_I) begin
      unique case (bst)
        B_IDLE: begin
          if (take) begin
            baddr <= HADDR_I;
            bwr <= HWRITE_I;
            HREADYOUT_O <= 1'b0;
            bst <= B_SERVE;
          end
        end
        B_SERVE: begin
          if (est == E_IDLE) begin
            HREADYOUT_O <= bwr;
            bst <= bwr ? B_IDLE : B_RDATA;
          end
        end
        B_RDATA: begin
          HRDATA_O <= rd_mux;
          HREADYOUT_O <= 1'b1;
          bst <= B_IDLE;
        end
      endcase
      HRESP_O <= size_unused & 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Execution sequence
  always_ff @(posedge MCLK_I) begin
    if (RESET_I) begin
      est <= E_IDLE;
      instr <= INSTR_RST;
      acc <= ACC_RST;
      flags <= mbae_flags_t'(FLAGS_RST);
      skip <= 1'b0;
      last_cycles <= 2'h0;
    end else if (CE_I) begin
      flags <= next_flags;
      unique case (est)
        E_IDLE: begin
          if (bus_wr_acc) acc <= HWDATA_I[7:0];
          if (bus_wr_instr) begin
            instr <= HWDATA_I[13:0];
            est <= E_READ;
          end
        end
        E_READ: est <= E_EXEC;
        E_EXEC: begin
          if (to_acc) acc <= alu;
          skip <= take_skip;
          last_cycles <= take_skip ? CYC_TWO : CYC_ONE;
          est <= take_skip ? E_NOP : E_IDLE;
        end
        E_NOP: est <= E_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Watchdog counter and prescaler
  always_ff @(posedge MCLK_I) begin
    if (RESET_I) begin
      wdt_pre <= '0;
      wdt_cnt <= '0;
    end else if (CE_I) begin
      if (wdt_clr) begin
        wdt_pre <= '0;
        wdt_cnt <= '0;
      end else begin
        wdt_pre <= wdt_pre + 1'b1;
        if (&wdt_pre) wdt_cnt <= wdt_cnt + 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge MCLK_I); endclocking
  default disable iff (RESET_I);

  bit_set_a: assert property (
    exec_ce && dec.op == OP_BSET |-> mem_we && mem_wdata[dec.bidx] &&
      ((mem_wdata ^ mem_rdata) & ~bmask) == 8'h00 ##1 $stable(flags) && est == E_IDLE)
    else $error("bit set wrong");

  bit_clear_a: assert property (
    exec_ce && dec.op == OP_BCLR |-> mem_we && !mem_wdata[dec.bidx] &&
      ((mem_wdata ^ mem_rdata) & ~bmask) == 8'h00 ##1 $stable(flags) && est == E_IDLE)
    else $error("bit clear wrong");

  test_skip_a: assert property (
    exec_ce && dec.op == OP_BTSC |=> (est == E_NOP) == $past(bit_is_clear) && !$past(mem_we)
      && last_cycles == ($past(bit_is_clear) ? CYC_TWO : CYC_ONE))
    else $error("bit test skip wrong");

  wdt_clear_a: assert property (
    exec_ce && dec.op == OP_WDTCLR |=> wdt_cnt == '0 && wdt_pre == '0 &&
      flags.watchdog_expired_flag && flags.sleep_entered_flag)
    else $error("watchdog clear wrong");

  complement_a: assert property (
    exec_ce && dec.op == OP_COMPLEMENT_FILE && !dec.dest |=> acc == ~$past(mem_rdata) &&
      flags.null_result_flag == ($past(mem_rdata) == 8'hFF))
    else $error("complement wrong");

  decrement_a: assert property (
    exec_ce && dec.op == OP_DECREMENT_FILE && dec.dest |-> mem_we && mem_wdata == mem_rdata - 8'h01
      ##1 flags.null_result_flag == ($past(mem_rdata) == 8'h01))
    else $error("decrement wrong");

  dec_skip_a: assert property (
    exec_ce && dec.op == OP_DECSZ |=> $stable(flags) &&
      (est == E_NOP) == ($past(mem_rdata) == 8'h01))
    else $error("decrement skip wrong");

  sub_literal_a: assert property (
    exec_ce && dec.op == OP_SUBL |=> acc == 8'($past(instr[7:0]) - $past(acc)) &&
      flags.borrow_not_flag == ($past(instr[7:0]) >= $past(acc)))
    else $error("literal subtract wrong");

  sub_file_a: assert property (
    exec_ce && dec.op == OP_SUBF && dec.dest |-> mem_we && mem_wdata == 8'(mem_rdata - acc)
      ##1 flags.null_result_flag == ($past(mem_rdata) == $past(acc)))
    else $error("file subtract wrong");

  borrow_flag_a: assert property (
    exec_ce && dec.op == OP_SUBF |=> flags.borrow_not_flag == ($past(mem_rdata) >= $past(acc)))
    else $error("borrow flag wrong");

  digit_borrow_a: assert property (
    exec_ce && is_sub |=> flags.digit_borrow_not_flag == ($past(sub_a[3:0]) >= $past(acc[3:0])))
    else $error("digit borrow wrong");

  dest_select_a: assert property (
    exec_ce && mbae_has_dest(dec.op) |-> mem_we == instr[7] ##1
      (instr[7] ? $stable(acc) : acc == $past(alu)))
    else $error("destination select wrong");

  // Unknown words leave file registers and accumulator alone and take one cycle
  nop_keeps_a: assert property (
    exec_ce && dec.op == OP_NOP |-> !mem_we ##1 $stable(acc) && est == E_IDLE &&
      last_cycles == CYC_ONE)
    else $error("no-op changed state");

  // Bus side and clock enable
  ce_freeze_a: assert property (
    !CE_I |=> $stable(est) && $stable(acc) && $stable(flags) && $stable(wdt_pre) &&
      $stable(bst) && $stable(HRDATA_O) && $stable(HREADYOUT_O))
    else $error("clock enable low did not freeze state");

  ready_low_a: assert property (
    take && CE_I |=> !HREADYOUT_O)
    else $error("ready not lowered on accepted transfer");

  acc_write_a: assert property (
    bus_wr_acc && CE_I |=> acc == $past(HWDATA_I[7:0]))
    else $error("accumulator bus write lost");

  bus_okay_a: assert property (HRESP_O == 1'b0)
    else $error("response not okay");

  skip_bit_c: cover property (exec_ce && dec.op == OP_BTSC && bit_is_clear);
  skip_dec_c: cover property (exec_ce && dec.op == OP_DECSZ && res_zero);
  sub_neg_c: cover property (exec_ce && dec.op == OP_SUBL && sub_diff[8]);
  nop_exec_c: cover property (exec_ce && dec.op == OP_NOP);
  ce_hold_c: cover property (!CE_I && bst == B_IDLE);

endmodule : mbae_core

// ===== tb_mcu_bit_arith_instruction_exec.sv
// Self-checking testbench for the bit and arithmetic instruction executor
`timescale 1ns/1ps
module tb_mcu_bit_arith_instruction_exec
  import mbae_pkg::*;
();

  ////////////////////////////////////////////////////////////////////////////////
  // Signals and design instance
  logic mclk = 1'b0;
  logic reset = 1'b1;
  logic ce = 1'b1;
  logic hsel = 1'b1;
  logic [ADDR_W-1:0] haddr = 12'h000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  wire logic [31:0] hrdata;
  wire logic hreadyout;
  wire logic hresp;
  int num_errors = 0;
  int n_tests = 0;
  logic [ADDR_W-1:0] fa;
  logic [31:0] v;
  logic [3:0] pre0;

  typedef struct packed {
    logic [13:0] iw;
    logic [7:0] fv;
    logic [7:0] acc;
    logic [7:0] st;
    logic [7:0] eacc;
    logic [7:0] ef;
    logic [7:0] est;
    logic [1:0] cyc;
  } mbae_row_t;

  // Instruction, file in, acc in, status in, acc out, file out, status out, cycles
  mbae_row_t rows [19] = '{
    '{14'h13A0, 8'hC7, 8'h00, 8'h07, 8'h00, 8'h47, 8'h07, 2'h1},
    '{14'h17FF, 8'h0A, 8'h00, 8'h00, 8'h00, 8'h8A, 8'h00, 2'h1},
    '{14'h1400, 8'h80, 8'h00, 8'h1F, 8'h00, 8'h81, 8'h1F, 2'h1},
    '{14'h18A1, 8'h00, 8'h00, 8'h18, 8'h00, 8'h00, 8'h38, 2'h2},
    '{14'h18A1, 8'h02, 8'h00, 8'h18, 8'h00, 8'h02, 8'h18, 2'h1},
    '{14'h0064, 8'h55, 8'h00, 8'h00, 8'h00, 8'h55, 8'h18, 2'h1},
    '{14'h0922, 8'h13, 8'h00, 8'h1C, 8'hEC, 8'h13, 8'h18, 2'h1},
    '{14'h09A2, 8'hFF, 8'h5A, 8'h18, 8'h5A, 8'h00, 8'h1C, 2'h1},
    '{14'h03A3, 8'h01, 8'h00, 8'h18, 8'h00, 8'h00, 8'h1C, 2'h1},
    '{14'h0323, 8'h00, 8'h00, 8'h1C, 8'hFF, 8'h00, 8'h18, 2'h1},
    '{14'h0BA4, 8'h01, 8'h00, 8'h18, 8'h00, 8'h00, 8'h38, 2'h2},
    '{14'h0B24, 8'h05, 8'h00, 8'h1F, 8'h04, 8'h05, 8'h1F, 2'h1},
    '{14'h3C02, 8'h33, 8'h01, 8'h18, 8'h01, 8'h33, 8'h1B, 2'h1},
    '{14'h3D02, 8'h33, 8'h02, 8'h18, 8'h00, 8'h33, 8'h1F, 2'h1},
    '{14'h3C02, 8'h33, 8'h03, 8'h1F, 8'hFF, 8'h33, 8'h18, 2'h1},
    '{14'h02A5, 8'h03, 8'h02, 8'h18, 8'h02, 8'h01, 8'h1B, 2'h1},
    '{14'h0225, 8'h10, 8'h01, 8'h18, 8'h0F, 8'h10, 8'h19, 2'h1},
    '{14'h02A5, 8'h01, 8'h02, 8'h1F, 8'h02, 8'hFF, 8'h18, 2'h1},
    '{14'h0000, 8'h3C, 8'h11, 8'h07, 8'h11, 8'h3C, 8'h07, 2'h1}
  };

  // Short prescaler so the watchdog counter moves within the run
  mbae_core #(
    .WDT_PRE_W(4),
    .WDT_CNT_W(8)
  ) u_mbae_core (
    .MCLK_I(mclk),
    .RESET_I(reset),
    .CE_I(ce),
    .HSEL_I(hsel),
    .HADDR_I(haddr),
    .HTRANS_I(htrans),
    .HWRITE_I(hwrite),
    .HSIZE_I(hsize),
    .HWDATA_I(hwdata),
    .HREADY_I(hreadyout),
    .HRDATA_O(hrdata),
    .HREADYOUT_O(hreadyout),
    .HRESP_O(hresp)
  );

  always #20 mclk = ~mclk;

  ////////////////////////////////////////////////////////////////////////////////
  // Bus and checking tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  // Entered just after a rising edge; holds each phase until ready is sampled
  task automatic xfer(input logic [ADDR_W-1:0] a, input logic w, input logic [31:0] wd);
    haddr <= a;
    hwrite <= w;
    htrans <= HTRANS_NONSEQ;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    v = hrdata;
    check({31'h0, hresp}, 32'h0);
  endtask : xfer

  task automatic bus_wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    xfer(a, 1'b1, d);
  endtask : bus_wr

  task automatic bus_rd(input logic [ADDR_W-1:0] a);
    xfer(a, 1'b0, 32'h0);
  endtask : bus_rd

  task automatic results;
    if (num_errors == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : results

  ////////////////////////////////////////////////////////////////////////////////
  // Stimulus
  initial begin
    repeat (5000) @(posedge mclk);
    num_errors++;
    results();
  end

  initial begin
    repeat (12) @(posedge mclk);
    reset <= 1'b0;
    @(posedge mclk);
    bus_rd(OFS_ACC);
    check(v, 32'h0);
    bus_rd(OFS_STATUS);
    check(v, 32'h18);
    foreach (rows[i]) begin
      fa = {FILE_SEL, rows[i].iw[6:0], 2'h0};
      bus_wr(fa, {24'h0, rows[i].fv});
      bus_wr(OFS_ACC, {24'h0, rows[i].acc});
      bus_wr(OFS_STATUS, {24'h0, rows[i].st});
      bus_wr(OFS_INSTR, {18'h0, rows[i].iw});
      bus_rd(OFS_ACC);
      check(v, {24'h0, rows[i].eacc});
      bus_rd(fa);
      check(v, {24'h0, rows[i].ef});
      bus_rd(OFS_STATUS);
      check(v, {24'h0, rows[i].est});
      bus_rd(OFS_CYCLES);
      check(v, {30'h0, rows[i].cyc});
      bus_rd(OFS_INSTR);
      check(v, {18'h0, rows[i].iw});
    end
    // Second instruction issued while the first still executes
    bus_wr({FILE_SEL, 7'h30, 2'h0}, 32'h0);
    bus_wr(OFS_INSTR, 32'h15B0);
    bus_wr(OFS_INSTR, 32'h03B0);
    bus_rd({FILE_SEL, 7'h30, 2'h0});
    check(v, 32'h07);
    // Unmapped place reads zero and ignores writes
    bus_wr(12'h020, 32'hFFFFFFFF);
    bus_rd(12'h020);
    check(v, 32'h0);
    bus_rd(OFS_WDT);
    check({31'h0, v[7:0] != 8'h00}, 32'h1);
    bus_wr(OFS_INSTR, 32'h0064);
    bus_rd(OFS_WDT);
    check({24'h0, v[7:0]}, 32'h0);
    // Clock enable low for five edges must not advance the prescaler
    pre0 = v[11:8];
    ce <= 1'b0;
    repeat (5) @(posedge mclk);
    ce <= 1'b1;
    bus_rd(OFS_WDT);
    check({28'h0, 4'(v[11:8] - pre0)}, 32'h4);
    // Reset in mid-run restores accumulator and flags
    bus_wr(OFS_STATUS, 32'h07);
    reset <= 1'b1;
    repeat (2) @(posedge mclk);
    check({31'h0, hreadyout}, 32'h1);
    check(hrdata, 32'h0);
    reset <= 1'b0;
    @(posedge mclk);
    bus_rd(OFS_ACC);
    check(v, 32'h0);
    bus_rd(OFS_STATUS);
    check(v, 32'h18);
    results();
  end

endmodule : tb_mcu_bit_arith_instruction_exec
